// ---- logic/acts_defs.svh ----
/*
 * Register offsets, field positions, reset values and timing figures
 * of the capture and trigger sequencer. Assumes a 50 MHz system clock.
 */
`ifndef ACTS_DEFS_SVH
`define ACTS_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define ACTS_A_CTRL    8'h00
`define ACTS_A_QUAL    8'h04
`define ACTS_A_PERIOD  8'h08
`define ACTS_A_DELAY   8'h0C
`define ACTS_A_REARM   8'h10
`define ACTS_A_CMD     8'h14
`define ACTS_A_STATUS  8'h18
`define ACTS_A_LVL     8'h20
`define ACTS_LVL_STEP  8'h08
// ****************************************
// Control fields
// ****************************************
`define ACTS_C_DEEP    0
`define ACTS_C_GL_AB   1
`define ACTS_C_GL_CD   2
`define ACTS_C_SEL_AB  3
`define ACTS_C_SEL_CD  5
`define ACTS_C_DLY_CD  7
`define ACTS_C_START   8
`define ACTS_C_SLP_A   10
`define ACTS_C_SLP_B   11
`define ACTS_CMD_RUN   0
`define ACTS_CMD_STOP  1
`define ACTS_CTRL_RST  32'h00000C00
// ****************************************
// Depths and limits
// ****************************************
`define ACTS_DEPTH_TG  12'd1024
`define ACTS_DEPTH_SD  12'd2048
`define ACTS_RSV_TG    12'd24
`define ACTS_DLY_TG    13'd5000
`define ACTS_DLY_SD    13'd6000
// ****************************************
// Timing
// ****************************************
`define ACTS_CLK_NS    20
`define ACTS_TMIN_SD_NS 20
`define ACTS_TMIN_TG_NS 50
`define ACTS_TMAX_MS   500
`define ACTS_SEC_NS    1000000000
`endif

// ---- logic/acts_pkg.sv ----
/*
 * Types of the capture and trigger sequencer.
 * Assumes nothing of its surroundings.
 */
package acts_pkg;
  typedef struct packed {
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } acts_word_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PRE = 3'b001, ST_TRACE = 3'b010,
    ST_DELAY = 3'b011, ST_DONE = 3'b100
  } acts_state_t;
  typedef enum logic [1:0] {
    FN_OFF = 2'b00, FN_MATCH = 2'b01, FN_NOT = 2'b10, FN_RESTART = 2'b11
  } acts_func_t;
  typedef enum logic [1:0] {
    CK_INT = 2'b00, CK_EXTA = 2'b01, CK_EXTB = 2'b10
  } acts_clksel_t;
  typedef struct packed {
    logic [7:0]  count;
    acts_func_t  func;
    logic [4:0]  pol;
    acts_word_t  word;
  } acts_level_t;
endpackage

// ---- logic/acts_capture_trigger.sv ----
/*
 * Acquisition control: sample clock choice, capture strobes, four-level
 * trigger sequencer and post-trigger delay. Assumes a capture memory
 * outside that takes the write strobes, and asynchronous probe pins.
 */
`timescale 1ns/10ps
`include "acts_defs.svh"
`default_nettype none
module acts_capture_trigger
  import acts_pkg::*;
#(
  parameter int unsigned MAX_PERIOD = `ACTS_TMAX_MS * 1000000 / `ACTS_CLK_NS,
  parameter int unsigned SEC_CYCLES = `ACTS_SEC_NS / `ACTS_CLK_NS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [31:0] probe_i,
  input  wire logic [7:0]  trig_qual_i,
  input  wire logic        external_clock_a_i,
  input  wire logic        external_clock_b_i,
  input  wire logic [2:0]  qual_a_i,
  input  wire logic [2:0]  qual_b_i,
  input  wire logic        key_run_i,
  output logic             cap_we_ab_o,
  output logic             cap_we_cd_o,
  output logic      [10:0] cap_addr_ab_o,
  output logic      [10:0] cap_addr_cd_o,
  output logic      [15:0] cap_data_ab_o,
  output logic      [15:0] cap_data_cd_o,
  output logic             glitch_en_ab_o,
  output logic             glitch_en_cd_o,
  output logic             parallel_bus_en_o,
  output logic      [1:0]  level_o,
  output logic             running_o
);
  localparam int unsigned TMIN_SD =
    (`ACTS_TMIN_SD_NS + `ACTS_CLK_NS - 1) / `ACTS_CLK_NS;
  localparam int unsigned TMIN_TG =
    (`ACTS_TMIN_TG_NS + `ACTS_CLK_NS - 1) / `ACTS_CLK_NS;

  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [11:0] qual_ff;
  logic [24:0] period_ff;
  logic [12:0] delay_ff;
  logic [7:0]  rearm_ff;
  logic [31:0] reg_rdata_ff;
  logic [31:0] nxt_rdata;
  acts_level_t lvl_ff [4];
  logic        wr_run;
  logic        wr_stop;

  assign wr_run  = reg_wr_i && reg_addr_i == `ACTS_A_CMD
                   && reg_wdata_i[`ACTS_CMD_RUN];
  assign wr_stop = reg_wr_i && reg_addr_i == `ACTS_A_CMD
                   && reg_wdata_i[`ACTS_CMD_STOP];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff   <= `ACTS_CTRL_RST;
      qual_ff   <= 12'h000;
      period_ff <= 25'h0000001;
      delay_ff  <= 13'h0000;
      rearm_ff  <= 8'h01;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ACTS_A_CTRL:   ctrl_ff <= reg_wdata_i;
        `ACTS_A_QUAL:   qual_ff <= reg_wdata_i[11:0];
        `ACTS_A_PERIOD: period_ff <= reg_wdata_i[24:0];
        `ACTS_A_DELAY:  delay_ff <= reg_wdata_i[12:0];
        `ACTS_A_REARM:  rearm_ff <= reg_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Level words and settings stay stored even when a level is off
  generate
    for (genvar l = 0; l < 4; l++) begin : g_lvl_reg
      localparam logic [7:0] BASE = 8'(`ACTS_A_LVL + l * `ACTS_LVL_STEP);
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          lvl_ff[l] <= '0;
        end else if (reg_wr_i && reg_addr_i == BASE) begin
          lvl_ff[l].word[31:0] <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == BASE + 8'h04) begin
          lvl_ff[l].word.q <= reg_wdata_i[7:0];
          lvl_ff[l].pol    <= reg_wdata_i[12:8];
          lvl_ff[l].func   <= acts_func_t'(reg_wdata_i[14:13]);
          lvl_ff[l].count  <= reg_wdata_i[23:16];
        end
      end
    end
  endgenerate

  logic        deep;
  logic [1:0]  start_mode;
  acts_clksel_t sel_ab;
  acts_clksel_t sel_cd;
  assign deep       = ctrl_ff[`ACTS_C_DEEP];
  assign start_mode = ctrl_ff[`ACTS_C_START +: 2];
  assign sel_ab     = acts_clksel_t'(ctrl_ff[`ACTS_C_SEL_AB +: 2]);
  assign sel_cd     = acts_clksel_t'(ctrl_ff[`ACTS_C_SEL_CD +: 2]);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = 49;
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  logic [2:0]    s3_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= 3'h0;
    end else begin
      s1_ff <= {key_run_i, external_clock_b_i, external_clock_a_i,
                qual_b_i, qual_a_i, trig_qual_i, probe_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[48:46];
    end
  end

  acts_word_t smp;
  logic [2:0] qa_s;
  logic [2:0] qb_s;
  assign smp  = s2_ff[39:0];
  assign qa_s = s2_ff[42:40];
  assign qb_s = s2_ff[45:43];

  function automatic logic qual_ok(input logic [2:0] q, input logic [5:0] c);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (c[2*i +: 2] == 2'b01 && !q[i]) ok = 1'b0;
      if (c[2*i +: 2] == 2'b10 && q[i]) ok = 1'b0;
    end
    return ok;
  endfunction

  // ****************************************
  // Sample clocks
  // ****************************************
  logic edge_a;
  logic edge_b;
  logic qok_a;
  logic qok_b;
  logic tick_ea;
  logic tick_eb;
  logic key_rise;
  assign edge_a = ctrl_ff[`ACTS_C_SLP_A] ? (s2_ff[46] && !s3_ff[0])
                                         : (!s2_ff[46] && s3_ff[0]);
  assign edge_b = ctrl_ff[`ACTS_C_SLP_B] ? (s2_ff[47] && !s3_ff[1])
                                         : (!s2_ff[47] && s3_ff[1]);
  assign qok_a  = qual_ok(qa_s, qual_ff[5:0]);
  assign qok_b  = qual_ok(qb_s, qual_ff[11:6]);
  // Qualifiers AND the edge; levels alone never tick
  assign tick_ea  = edge_a && qok_a;
  assign tick_eb  = edge_b && qok_b;
  assign key_rise = s2_ff[48] && !s3_ff[2];

  // Period clamped; 3-cycle (60ns) floor when two groups run
  logic [24:0] per_lim;
  logic [24:0] per_cnt_ff;
  logic        tick_int;
  always_comb begin
    per_lim = period_ff;
    if (per_lim < 25'(deep ? TMIN_SD : TMIN_TG)) per_lim = 25'(deep ? TMIN_SD : TMIN_TG);
    if (per_lim > 25'(MAX_PERIOD)) per_lim = 25'(MAX_PERIOD);
  end
  assign tick_int = per_cnt_ff >= per_lim - 25'h0000001;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || tick_int) per_cnt_ff <= 25'h0000000;
    else per_cnt_ff <= per_cnt_ff + 25'h0000001;
  end

  function automatic logic pick(input acts_clksel_t s, input logic i,
                                input logic a, input logic b);
    case (s)
      CK_EXTA: return a;
      CK_EXTB: return b;
      default: return i;
    endcase
  endfunction

  logic tick_ab;
  logic tick_cd;
  logic tick_dly;
  assign tick_ab  = pick(sel_ab, tick_int, tick_ea, tick_eb);
  // Pair C/D is off in deep mode
  assign tick_cd  = !deep && pick(sel_cd, tick_int, tick_ea, tick_eb);
  // Delay clock chosen only with two differing clocks
  assign tick_dly = (!deep && sel_ab != sel_cd && ctrl_ff[`ACTS_C_DLY_CD])
                    ? tick_cd : tick_ab;

  // ****************************************
  // Trigger word compare
  // ****************************************
  logic [3:0] match;
  generate
    for (genvar l = 0; l < 4; l++) begin : g_match
      logic [4:0] grp;
      for (genvar g = 0; g < 5; g++) begin : g_grp
        assign grp[g] = (smp[8*g +: 8] ^ {8{lvl_ff[l].pol[g]}})
                        == lvl_ff[l].word[8*g +: 8];
      end
      assign match[l] = &grp;
    end
  endgenerate

  // ****************************************
  // Recording sequencer
  // ****************************************
  acts_state_t state_ff;
  logic [1:0]  lvl_ff_idx;
  logic [7:0]  evt_ff;
  logic [11:0] pre_ff;
  logic [12:0] dly_ff;
  logic [12:0] dly_lim;
  logic [11:0] depth;
  logic [11:0] pre_tgt;
  logic        go;
  logic        rec;
  logic        rst_hit;
  logic        rearm_go;
  acts_level_t cur;
  logic [7:0]  need;

  assign dly_lim = (delay_ff > (deep ? `ACTS_DLY_SD : `ACTS_DLY_TG))
                   ? (deep ? `ACTS_DLY_SD : `ACTS_DLY_TG) : delay_ff;
  assign depth   = deep ? `ACTS_DEPTH_SD : `ACTS_DEPTH_TG;
  // Pre-trigger fill is depth minus delay
  assign pre_tgt = ({1'b0, depth} > dly_lim) ? 12'({1'b0, depth} - dly_lim) : 12'h000;
  assign rec     = state_ff == ST_PRE || state_ff == ST_TRACE
                   || state_ff == ST_DELAY;
  // Key and command start; serial mode still takes commands
  assign go      = (wr_run || key_rise || rearm_go) && !wr_stop;
  assign cur     = lvl_ff[lvl_ff_idx];
  assign need    = (cur.count == 8'h00) ? 8'h01 : cur.count;
  // Abort word on level 4 during levels 2 and 3
  assign rst_hit = lvl_ff[3].func == FN_RESTART && match[3]
                   && (lvl_ff_idx == 2'd1 || lvl_ff_idx == 2'd2);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || wr_stop) begin
      state_ff   <= ST_IDLE;
      lvl_ff_idx <= 2'd0;
      evt_ff     <= 8'h00;
      pre_ff     <= 12'h000;
      dly_ff     <= 13'h0000;
    end else if (go) begin
      state_ff   <= ST_PRE;
      lvl_ff_idx <= 2'd0;
      evt_ff     <= 8'h00;
      pre_ff     <= 12'h000;
      dly_ff     <= dly_lim;
    end else begin
      case (state_ff)
        ST_PRE: begin
          if (pre_ff >= pre_tgt) state_ff <= ST_TRACE;
          else if (tick_ab) pre_ff <= pre_ff + 12'h001;
        end
        ST_TRACE: begin
          if (lvl_ff_idx == 2'd0 && cur.func == FN_OFF) begin
            state_ff <= ST_DELAY;
          // Skipped level passes on at once
          end else if (lvl_ff_idx != 2'd0 &&
                       (cur.func == FN_OFF || cur.func == FN_RESTART)) begin
            evt_ff <= 8'h00;
            if (lvl_ff_idx == 2'd3) state_ff <= ST_DELAY;
            else lvl_ff_idx <= lvl_ff_idx + 2'd1;
          end else if (tick_ab) begin
            if (rst_hit) begin
              lvl_ff_idx <= 2'd0;
              evt_ff     <= 8'h00;
            // Exclusion checks the very next word
            end else if (lvl_ff_idx != 2'd0 && cur.func == FN_NOT) begin
              evt_ff <= 8'h00;
              if (match[lvl_ff_idx]) lvl_ff_idx <= 2'd0;
              else if (lvl_ff_idx == 2'd3) state_ff <= ST_DELAY;
              else lvl_ff_idx <= lvl_ff_idx + 2'd1;
            end else if (match[lvl_ff_idx]) begin
              if (evt_ff + 8'h01 >= need) begin
                evt_ff <= 8'h00;
                if (lvl_ff_idx == 2'd3) state_ff <= ST_DELAY;
                else lvl_ff_idx <= lvl_ff_idx + 2'd1;
              end else begin
                evt_ff <= evt_ff + 8'h01;
              end
            end
          end
        end
        ST_DELAY: begin
          if (dly_ff == 13'h0000) state_ff <= ST_DONE;
          else if (tick_dly) dly_ff <= dly_ff - 13'h0001;
        end
        ST_DONE: ;
        ST_IDLE: ;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Periodic rearm
  // ****************************************
  logic [31:0] sec_ff;
  logic [7:0]  secs_ff;
  logic        sec_tick;
  assign sec_tick = sec_ff >= SEC_CYCLES - 1;
  // Rearm every programmed seconds after a run
  assign rearm_go = start_mode == 2'b01 && state_ff == ST_DONE && sec_tick
                    && secs_ff + 8'h01 >= ((rearm_ff == 8'h00) ? 8'h01 : rearm_ff);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || state_ff != ST_DONE || sec_tick) sec_ff <= 32'h00000000;
    else sec_ff <= sec_ff + 32'h00000001;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || state_ff != ST_DONE || rearm_go) secs_ff <= 8'h00;
    else if (sec_tick) secs_ff <= secs_ff + 8'h01;
  end

  // ****************************************
  // Capture strobes
  // ****************************************
  logic        we_ab_ff;
  logic        we_cd_ff;
  logic [10:0] addr_ab_ff;
  logic [10:0] addr_cd_ff;
  logic [15:0] dat_ab_ff;
  logic [15:0] dat_cd_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || go) begin
      we_ab_ff   <= 1'b0;
      addr_ab_ff <= 11'h7FF;
      dat_ab_ff  <= 16'h0000;
    end else begin
      // Store on each sample tick while recording
      we_ab_ff <= rec && tick_ab;
      if (rec && tick_ab) begin
        dat_ab_ff  <= {smp.b, smp.a};
        addr_ab_ff <= (addr_ab_ff >= 11'(depth - 12'h001)) ? 11'h000
                      : addr_ab_ff + 11'h001;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || go) begin
      we_cd_ff   <= 1'b0;
      addr_cd_ff <= 11'h7FF;
      dat_cd_ff  <= 16'h0000;
    end else begin
      we_cd_ff <= rec && tick_cd;
      if (rec && tick_cd) begin
        dat_cd_ff  <= {smp.d, smp.c};
        addr_cd_ff <= (addr_cd_ff >= 11'(`ACTS_DEPTH_TG - 12'h001)) ? 11'h000
                      : addr_cd_ff + 11'h001;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (reg_addr_i)
      `ACTS_A_CTRL:   nxt_rdata = ctrl_ff;
      `ACTS_A_QUAL:   nxt_rdata = {20'h00000, qual_ff};
      `ACTS_A_PERIOD: nxt_rdata = {7'h00, period_ff};
      `ACTS_A_DELAY:  nxt_rdata = {19'h00000, delay_ff};
      `ACTS_A_REARM:  nxt_rdata = {24'h000000, rearm_ff};
      `ACTS_A_STATUS: nxt_rdata = {8'h00, dly_ff, evt_ff[5:0],
                                   state_ff, lvl_ff_idx};
      default: begin
        for (int l = 0; l < 4; l++) begin
          if (reg_addr_i == 8'(`ACTS_A_LVL + l * `ACTS_LVL_STEP))
            nxt_rdata = lvl_ff[l].word[31:0];
          if (reg_addr_i == 8'(`ACTS_A_LVL + l * `ACTS_LVL_STEP + 4))
            nxt_rdata = {8'h00, lvl_ff[l].count, 1'b0, lvl_ff[l].func,
                         lvl_ff[l].pol, lvl_ff[l].word.q};
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) reg_rdata_ff <= 32'h00000000;
    else if (reg_rd_i) reg_rdata_ff <= nxt_rdata;
    else reg_rdata_ff <= 32'h00000000;
  end

  assign reg_rdata_o   = reg_rdata_ff;
  assign cap_we_ab_o   = we_ab_ff;
  assign cap_we_cd_o   = we_cd_ff;
  assign cap_addr_ab_o = addr_ab_ff;
  assign cap_addr_cd_o = addr_cd_ff;
  assign cap_data_ab_o = dat_ab_ff;
  assign cap_data_cd_o = dat_cd_ff;
  assign glitch_en_ab_o = ctrl_ff[`ACTS_C_GL_AB];
  assign glitch_en_cd_o = ctrl_ff[`ACTS_C_GL_CD] && !deep;
  // Serial host mode locks out the parallel bus
  assign parallel_bus_en_o = start_mode != 2'b10;
  assign level_o   = lvl_ff_idx;
  assign running_o = rec;

  // ****************************************
  // Checks
  // ****************************************
  AST_START_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    go |=> state_ff == ST_PRE && lvl_ff_idx == 2'd0 && evt_ff == 8'h00)
    else $error("start did not reset sequencer");
  AST_CAP_EDGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rec && tick_ab && !go && !wr_stop |=> cap_we_ab_o)
    else $error("missed capture strobe");
  AST_QUAL_GATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sel_ab == CK_EXTA && !(edge_a && qok_a) |=> !cap_we_ab_o)
    else $error("unqualified edge captured");
  AST_DEEP_CD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    deep && $past(deep) |-> !cap_we_cd_o)
    else $error("C/D captured in deep mode");
  AST_DLY_DONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_DELAY && dly_ff == 13'h0000 && !go && !wr_stop
    |=> state_ff == ST_DONE ##1 !cap_we_ab_o)
    else $error("delay end did not stop");
  AST_SEQ_ORDER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_TRACE && $changed(lvl_ff_idx) && lvl_ff_idx != 2'd0
    |-> lvl_ff_idx == 2'($past(lvl_ff_idx) + 2'd1))
    else $error("level skipped order");
  AST_NOT_BACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_TRACE && tick_ab && lvl_ff_idx != 2'd0 && cur.func == FN_NOT
    && match[lvl_ff_idx] && !go && !wr_stop |=> lvl_ff_idx == 2'd0)
    else $error("excluded word did not return");
  AST_FREE_FILL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_TRACE && lvl_ff_idx == 2'd0 && cur.func == FN_OFF
    && !go && !wr_stop |=> state_ff == ST_DELAY)
    else $error("fill did not bypass levels");
  AST_PER_MIN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !deep && tick_int |-> per_cnt_ff >= 25'(TMIN_TG - 1))
    else $error("period below floor");
endmodule // acts_capture_trigger
`default_nettype wire

// ---- test/acts_target_model.sv ----
/*
 * Target circuit model: probe data and one external clock.
 * Assumes the bench enables it only while a frame should run.
 */
`timescale 1ns/10ps
`default_nettype none
module acts_target_model (
  input  wire logic        en_i,
  output logic      [31:0] probe_o,
  output logic      [7:0]  tq_o,
  output logic             clk_a_o,
  output logic      [15:0] last_o
);
  initial begin
    probe_o = $urandom;
    tq_o = 8'h00;
    clk_a_o = 1'b0;
    last_o = 16'h0000;
    #7;
    forever begin
      #80;
      if (en_i) begin
        clk_a_o = ~clk_a_o;
        // Data moves on the fall, stable at the rise
        if (clk_a_o) last_o = probe_o[15:0];
        else probe_o = $urandom;
      end
    end
  end
endmodule // acts_target_model
`default_nettype wire

// ---- test/acts_capture_trigger_tb_top.sv ----
/*
 * Bench of the capture and trigger sequencer.
 * Assumes the target model beside it and a 50 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module acts_capture_trigger_tb_top;
  logic        clk, rst_n, wr_s, rd_s, en, pbe, run, gab, gcd, ca, we, chk_on, key;
  logic [7:0]  addr, tq;
  logic [31:0] wd, rdat, pr, v, d;
  logic [2:0]  qa;
  logic [1:0]  lvl;
  logic [15:0] cd, last;
  logic [10:0] ad;
  logic [31:0] l2c [5] = '{32'h0, 32'h00012000, 32'h00014000, 32'h0, 32'h00022000};
  int          bad_count, tests_run, we_n, cyc;
  acts_capture_trigger #(.MAX_PERIOD(100), .SEC_CYCLES(50)) uut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .probe_i(pr),
    .trig_qual_i(tq), .external_clock_a_i(ca), .external_clock_b_i(1'b0),
    .qual_a_i(qa), .qual_b_i(3'h0), .key_run_i(key), .cap_we_ab_o(we),
    .cap_we_cd_o(), .cap_addr_ab_o(ad), .cap_addr_cd_o(), .cap_data_ab_o(cd),
    .cap_data_cd_o(), .glitch_en_ab_o(gab), .glitch_en_cd_o(gcd),
    .parallel_bus_en_o(pbe), .level_o(lvl), .running_o(run));
  acts_target_model tgt (.en_i(en), .probe_o(pr), .tq_o(tq), .clk_a_o(ca), .last_o(last));
  // ****
  // Bus and check tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wd <= x;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 x = rdat;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Setups 0 and 1 reach the end, 2 to 4 stay in trace
  function automatic logic [31:0] exp_state(input int i);
    return (i < 2) ? 32'h4 : 32'h2;
  endfunction
  task automatic go(input int n);
    wr(8'h14, 32'h1);
    @(posedge clk);
    #1;
    for (int i = 0; i < n && run !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (we === 1'b1) we_n++;
    // stored data is the edge's data
    if (we === 1'b1 && chk_on) chk({16'h0, cd}, {16'h0, last});
    if (cyc == 60000) begin
      bad_count++;
      complete_run;
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {wr_s, rd_s, en, chk_on, rst_n, key} = 6'h00;
    addr = 8'h00;
    wd = 32'h0;
    qa = 3'h0;
    void'($urandom(32'hF3C0));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, v);
    chk(v, 32'h00000C00);
    rd(8'h44, v);
    chk(v, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h0C00 | (m << 8));
      @(posedge clk);
      #1 chk({31'h0, pbe}, {31'h0, m != 2});
    end
    for (int g = 0; g < 2; g++) begin
      wr(8'h00, g ? 32'h0C06 : 32'h0C07);
      @(posedge clk);
      #1 chk({30'h0, gab, gcd}, g ? 32'h3 : 32'h2);
    end
    // Periodic start, so the rearm is seen after the run
    wr(8'h00, 32'h0D00);
    wr(8'h08, 32'h3);
    d = $urandom_range(200, 1);
    wr(8'h0C, d);
    wr(8'h24, 32'h0);
    we_n = 0;
    go(4000);
    chk({31'h0, we_n inside {[1024:1025]}}, 32'h1);
    rd(8'h18, v);
    chk({16'h0, v[23:11], v[4:2]}, 32'h4);
    chk({21'h0, ad}, 32'h3FF);
    repeat (60) @(posedge clk);
    #1 chk({31'h0, run}, 32'h1);
    wr(8'h34, 32'h0);
    // Probe stands still, so the word is known
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, pr ^ {31'h0, i == 3});
      wr(8'h24, 32'h00032000);
      wr(8'h28, pr);
      wr(8'h2C, l2c[i]);
      wr(8'h38, pr);
      wr(8'h3C, (i == 4) ? 32'h6000 : 32'h0);
      go(4000);
      rd(8'h18, v);
      chk({29'h0, v[4:2]}, exp_state(i));
      if (i == 3) chk({30'h0, lvl}, 32'h0);
      wr(8'h14, 32'h2);
    end
    key <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({31'h0, run}, 32'h1);
    wr(8'h14, 32'h2);
    key <= 1'b0;
    wr(8'h00, 32'h0C08);
    wr(8'h04, 32'h1);
    wr(8'h0C, 32'h0);
    wr(8'h24, 32'h0);
    en <= 1'b1;
    we_n = 0;
    wr(8'h14, 32'h1);
    repeat (300) @(posedge clk);
    chk(we_n, 32'h0);
    qa <= 3'h1;
    chk_on = 1'b1;
    repeat (300) @(posedge clk);
    chk({31'h0, we_n > 10}, 32'h1);
    complete_run;
  end
endmodule // acts_capture_trigger_tb_top
`default_nettype wire
